// ==== hw/attc_phase_timer.sv ====
// Purpose: down counter timing one phase of a strobe sequence
// Assumes: load_val is at least one
// Notes:   a phase loaded with n lasts n cycles; last marks its final one
`timescale 1ns/1ns
module attc_phase_timer (
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic                     load,
    input  wire logic [attc_pkg::TMR_W-1:0] load_val,
    output logic      [attc_pkg::TMR_W-1:0] cnt,
    output logic                          last
);
    import attc_pkg::*;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } attc_tmr_t;

    attc_tmr_t q;
    attc_tmr_t d;

    always_comb begin
        d = q;
        if (load) begin
            d.cnt = load_val;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - TMR_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt  = q.cnt;
    assign last = (q.cnt == TMR_W'(1));

endmodule : attc_phase_timer

// ==== hw/attc_pkg.sv ====
// Purpose: constants for the drive-side transfer timing configuration block
// Assumes: 8-bit microcontroller data space, 16-bit addresses
// Notes:   all counts are in cycles of clk_sys
package attc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] OFF_PIO_ASSERT_TIME   = 16'hf0dc;
    localparam logic [15:0] OFF_PIO_RECOVERY_TIME = 16'hf0dd;
    localparam logic [15:0] OFF_DMA_ASSERT_TIME   = 16'hf0de;

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int          CNT_W           = 5;
    localparam int          TMR_W           = 6;
    localparam int          BIT_USB_SM_RST  = 7;
    localparam int          BIT_DIR_HINT    = 7;
    localparam logic [4:0]  RST_COUNT       = 5'h00;
    localparam logic [7:0]  RST_RDATA       = 8'h00;

    // ------------------------------------------------------------------
    // extra cycles added to programmed values, and write hold lengths
    // ------------------------------------------------------------------
    localparam logic [5:0]  EXTRA_PIO_ASSERT = 6'h01;
    localparam logic [5:0]  EXTRA_PIO_RECOV  = 6'h02;
    localparam logic [5:0]  EXTRA_MWDMA_AST  = 6'h01;
    localparam logic [5:0]  EXTRA_UDMA_AST   = 6'h02;
    localparam logic [5:0]  PIO_WR_HOLD      = 6'h02;
    localparam logic [5:0]  UDMA_WR_HOLD     = 6'h01;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_ASSERT  = 3'b010,
        ST_RECOVER = 3'b100
    } attc_state_t;

endpackage : attc_pkg

// ==== hw/attc_timing_cfg.sv ====
// Purpose: transfer timing registers and the strobe phase sequencer
// Assumes: nrst is the power-up / watchdog reset; bus reset never reaches here
// Notes:   register reads answer one cycle after xd_rd
`timescale 1ns/1ns
module attc_timing_cfg (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [15:0] xd_addr,
    input  wire logic [7:0]  xd_wdata,
    input  wire logic        xd_wr,
    input  wire logic        xd_rd,
    output logic      [7:0]  xd_rdata,
    output logic             usb_sm_idle,
    output logic             dma_direction_hint_enable,
    input  wire logic        xfer_start,
    input  wire logic        xfer_dma,
    input  wire logic        xfer_udma,
    input  wire logic        xfer_write,
    output logic             xfer_busy,
    output logic             xfer_done,
    output logic             strobe,
    output logic             data_hold,
    output logic             recovery
);
    import attc_pkg::*;

    typedef struct packed {
        attc_state_t      st;
        logic [CNT_W-1:0] pio_assert_count;
        logic [CNT_W-1:0] pio_recovery_count;
        logic [CNT_W-1:0] dma_assert_count;
        logic             dir_hint;
        logic [7:0]       rdata;
        logic             sm_idle;
        logic             done;
        logic             is_dma;
        logic             udma;
        logic             wr;
        logic [CNT_W-1:0] lat_ast;
        logic [CNT_W-1:0] lat_rcv;
    } attc_state_s_t;

    attc_state_s_t    q;
    attc_state_s_t    d;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic [TMR_W-1:0] tmr_cnt;
    logic             tmr_last;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    attc_phase_timer u_timer (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .cnt      (tmr_cnt),
        .last     (tmr_last)
    );

    // ------------------------------------------------------------------
    // registers and sequencer
    // ------------------------------------------------------------------
    always_comb begin
        d         = q;
        d.sm_idle = 1'b0;
        d.done    = 1'b0;
        tmr_load  = 1'b0;
        tmr_val   = '0;
        if (xd_wr && hit(xd_addr, OFF_PIO_ASSERT_TIME)) begin
            d.pio_assert_count = xd_wdata[CNT_W-1:0];
            d.sm_idle          = xd_wdata[BIT_USB_SM_RST];
        end
        if (xd_wr && hit(xd_addr, OFF_PIO_RECOVERY_TIME)) begin
            d.pio_recovery_count = xd_wdata[CNT_W-1:0];
        end
        if (xd_wr && hit(xd_addr, OFF_DMA_ASSERT_TIME)) begin
            d.dma_assert_count = xd_wdata[CNT_W-1:0];
            d.dir_hint         = xd_wdata[BIT_DIR_HINT];
        end
        if (xd_rd) begin
            d.rdata = 8'h00;
            if (hit(xd_addr, OFF_PIO_ASSERT_TIME)) begin
                d.rdata = {3'h0, q.pio_assert_count};
            end else if (hit(xd_addr, OFF_PIO_RECOVERY_TIME)) begin
                d.rdata = {3'h0, q.pio_recovery_count};
            end else if (hit(xd_addr, OFF_DMA_ASSERT_TIME)) begin
                d.rdata = {q.dir_hint, 2'h0, q.dma_assert_count};
            end
        end
        unique case (q.st)
            ST_IDLE: begin
                if (xfer_start) begin
                    d.st      = ST_ASSERT;
                    d.is_dma  = xfer_dma;
                    d.udma    = xfer_udma;
                    d.wr      = xfer_write;
                    d.lat_ast = xfer_dma ? q.dma_assert_count : q.pio_assert_count;
                    d.lat_rcv = q.pio_recovery_count;
                    tmr_load  = 1'b1;
                    if (!xfer_dma) begin
                        tmr_val = {1'b0, q.pio_assert_count} + EXTRA_PIO_ASSERT;
                    end else if (xfer_udma) begin
                        tmr_val = {1'b0, q.dma_assert_count} + EXTRA_UDMA_AST;
                    end else begin
                        tmr_val = {1'b0, q.dma_assert_count} + EXTRA_MWDMA_AST;
                    end
                end
            end
            ST_ASSERT: begin
                if (tmr_last) begin
                    if (!q.is_dma) begin
                        d.st     = ST_RECOVER;
                        tmr_load = 1'b1;
                        tmr_val  = {1'b0, q.lat_rcv} + EXTRA_PIO_RECOV;
                    end else begin
                        d.st   = ST_IDLE;
                        d.done = 1'b1;
                    end
                end
            end
            ST_RECOVER: begin
                if (tmr_last) begin
                    d.st   = ST_IDLE;
                    d.done = 1'b1;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q                    <= '0;
            q.st                 <= ST_IDLE;
            q.pio_assert_count   <= RST_COUNT;
            q.pio_recovery_count <= RST_COUNT;
            q.dma_assert_count   <= RST_COUNT;
            q.rdata              <= RST_RDATA;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic udma_wr_hold;
    assign udma_wr_hold = (q.st == ST_ASSERT) && q.is_dma && q.udma && q.wr && tmr_last;

    assign xd_rdata                  = q.rdata;
    assign usb_sm_idle               = q.sm_idle;
    assign dma_direction_hint_enable = q.dir_hint;
    assign xfer_busy                 = (q.st != ST_IDLE);
    assign xfer_done                 = q.done;
    assign strobe                    = (q.st == ST_ASSERT) && !udma_wr_hold;
    assign recovery                  = (q.st == ST_RECOVER);
    assign data_hold                 = udma_wr_hold
                                     || ((q.st == ST_RECOVER) && q.wr
                                         && (tmr_cnt > {1'b0, q.lat_rcv}));

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [7:0] ph_len;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ph_len <= 8'h00;
        end else begin
            ph_len <= (d.st != q.st) ? 8'h00 : ph_len + 8'h01;
        end
    end

    AST_REGS_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        !xd_wr |=> $stable(q.pio_assert_count) && $stable(q.pio_recovery_count)
                   && $stable(q.dma_assert_count))
        else $error("timing register changed without a write");
    AST_PIO_AST_LEN: assert property (@(posedge clk_sys) disable iff (!nrst)
        (q.st == ST_ASSERT) && !q.is_dma && tmr_last |-> ph_len == {3'h0, q.lat_ast})
        else $error("pio strobe length wrong");
    AST_PIO_RCV_LEN: assert property (@(posedge clk_sys) disable iff (!nrst)
        (q.st == ST_RECOVER) && tmr_last |-> ph_len == ({3'h0, q.lat_rcv} + 8'h01)
        ##1 !xfer_busy)
        else $error("pio recovery length wrong");
    AST_PIO_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        (q.st == ST_RECOVER) && q.wr |-> (data_hold == (ph_len < 8'h02)))
        else $error("pio write hold not two cycles");
    AST_DMA_AST_LEN: assert property (@(posedge clk_sys) disable iff (!nrst)
        (q.st == ST_ASSERT) && q.is_dma && tmr_last
        |-> ph_len == ({3'h0, q.lat_ast} + {7'h00, q.udma}) ##1 xfer_done && !xfer_busy)
        else $error("dma assertion length wrong");
    AST_UDMA_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        $fell(strobe) && q.is_dma && q.udma && q.wr |-> data_hold ##1 !data_hold)
        else $error("ultra dma write hold wrong");
    AST_USB_IDLE: assert property (@(posedge clk_sys) disable iff (!nrst)
        xd_wr && hit(xd_addr, OFF_PIO_ASSERT_TIME) && xd_wdata[BIT_USB_SM_RST]
        |=> usb_sm_idle ##1 !usb_sm_idle)
        else $error("usb machine reset pulse missing");
    AST_RST_BIT_RD0: assert property (@(posedge clk_sys) disable iff (!nrst)
        xd_rd && hit(xd_addr, OFF_PIO_ASSERT_TIME) |=> xd_rdata[7:5] == 3'h0)
        else $error("write-only bit read back");
    AST_RSV_RD0: assert property (@(posedge clk_sys) disable iff (!nrst)
        xd_rd && (hit(xd_addr, OFF_PIO_RECOVERY_TIME) || hit(xd_addr, OFF_DMA_ASSERT_TIME))
        |=> xd_rdata[6:5] == 2'h0)
        else $error("reserved bits not zero");

endmodule : attc_timing_cfg

// ==== verif/attc_drive_model.sv ====
// Purpose: drive-side model that counts strobe, hold and recovery cycles
// Assumes: clear is high on the edge at which a transfer is taken
// Notes:   counts stay until the next clear
`timescale 1ns/1ns
module attc_drive_model (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       clear,
    input  wire logic       strobe,
    input  wire logic       data_hold,
    input  wire logic       recovery,
    output logic      [7:0] strobe_cycles,
    output logic      [7:0] hold_cycles,
    output logic      [7:0] recov_cycles
);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            strobe_cycles <= 8'h00;
            hold_cycles   <= 8'h00;
            recov_cycles  <= 8'h00;
        end else if (clear) begin
            strobe_cycles <= 8'h00;
            hold_cycles   <= 8'h00;
            recov_cycles  <= 8'h00;
        end else begin
            strobe_cycles <= strobe_cycles + {7'h00, strobe};
            hold_cycles   <= hold_cycles + {7'h00, data_hold};
            recov_cycles  <= recov_cycles + {7'h00, recovery};
        end
    end
endmodule : attc_drive_model

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the transfer timing configuration block
// Assumes: single-byte register accesses, one transfer at a time
// Notes:   phase lengths are measured by the drive model
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
    import attc_pkg::*;
    logic        clk_sys, nrst, xd_wr, xd_rd, p, clr;
    logic        xfer_start, xfer_dma, xfer_udma, xfer_write;
    logic        usb_sm_idle, dir_en, xfer_busy, xfer_done, strobe, data_hold, recovery;
    logic [15:0] xd_addr;
    logic [7:0]  xd_wdata, xd_rdata, s_cnt, h_cnt, r_cnt, c;
    logic [7:0]  cnts [3] = '{8'h00, 8'h1f, 8'h09};
    int          fails, samples_checked;

    always #25 clk_sys = ~clk_sys;
    assign clr = xfer_start & ~xfer_busy;

    attc_timing_cfg DUT (.clk_sys(clk_sys), .nrst(nrst), .xd_addr(xd_addr),
        .xd_wdata(xd_wdata), .xd_wr(xd_wr), .xd_rd(xd_rd), .xd_rdata(xd_rdata),
        .usb_sm_idle(usb_sm_idle), .dma_direction_hint_enable(dir_en),
        .xfer_start(xfer_start), .xfer_dma(xfer_dma), .xfer_udma(xfer_udma),
        .xfer_write(xfer_write), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
        .strobe(strobe), .data_hold(data_hold), .recovery(recovery));
    attc_drive_model drive (.clk_sys(clk_sys), .nrst(nrst), .clear(clr), .strobe(strobe),
        .data_hold(data_hold), .recovery(recovery), .strobe_cycles(s_cnt),
        .hold_cycles(h_cnt), .recov_cycles(r_cnt));

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic pulse);
        @(posedge clk_sys);
        xd_addr  <= a;
        xd_wdata <= d;
        xd_wr    <= 1'b1;
        @(posedge clk_sys);
        xd_wr <= 1'b0;
        #1 pulse = usb_sm_idle;
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        xd_addr <= a;
        xd_rd   <= 1'b1;
        @(posedge clk_sys);
        xd_rd <= 1'b0;
        #1 `CHK("xd_rdata", e, xd_rdata)
    endtask : rd_chk

    task automatic run(input logic dm, ud, w, input logic [7:0] es, eh, er);
        int n;
        n = 0;
        @(posedge clk_sys);
        xfer_start <= 1'b1;
        xfer_dma   <= dm;
        xfer_udma  <= ud;
        xfer_write <= w;
        @(posedge clk_sys);
        #1 `CHK("xfer_busy", 1'b1, xfer_busy)
        @(posedge clk_sys);
        xfer_start <= 1'b0;
        #1;
        while (xfer_done !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1 n++;
        end
        `CHK("xfer_done", 1'b1, xfer_done)
        `CHK("xfer_busy", 1'b0, xfer_busy)
        `CHK("strobe_cycles", es, s_cnt)
        `CHK("hold_cycles", eh, h_cnt)
        `CHK("recov_cycles", er, r_cnt)
    endtask : run

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        #1000000 fails++;
        results();
    end

    initial begin
        {clk_sys, nrst, xd_wr, xd_rd, xfer_start, xfer_dma, xfer_udma, xfer_write} = 8'h00;
        {xd_addr, xd_wdata} = 24'h000000;
        {fails, samples_checked} = 0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        rd_chk(OFF_PIO_ASSERT_TIME, 8'h00);
        rd_chk(OFF_DMA_ASSERT_TIME, 8'h00);
        wr(OFF_PIO_ASSERT_TIME, 8'hff, p);
        `CHK("usb_sm_idle", 1'b1, p)
        wr(OFF_PIO_RECOVERY_TIME, 8'hff, p);
        `CHK("usb_sm_idle", 1'b0, p)
        wr(OFF_DMA_ASSERT_TIME, 8'hff, p);
        `CHK("dir_hint", 1'b1, dir_en)
        rd_chk(OFF_PIO_ASSERT_TIME, 8'h1f);
        rd_chk(OFF_PIO_RECOVERY_TIME, 8'h1f);
        rd_chk(OFF_DMA_ASSERT_TIME, 8'h9f);
        rd_chk(16'hf0df, 8'h00);
        foreach (cnts[i]) begin
            c = cnts[i];
            wr(OFF_PIO_ASSERT_TIME, c, p);
            `CHK("usb_sm_idle", 1'b0, p)
            wr(OFF_PIO_RECOVERY_TIME, c, p);
            wr(OFF_DMA_ASSERT_TIME, c, p);
            run(1'b0, 1'b0, 1'b1, c + 8'h01, 8'h02, c + 8'h02);
            run(1'b0, 1'b0, 1'b0, c + 8'h01, 8'h00, c + 8'h02);
            run(1'b1, 1'b0, 1'b0, c + 8'h01, 8'h00, 8'h00);
            run(1'b1, 1'b0, 1'b1, c + 8'h01, 8'h00, 8'h00);
            run(1'b1, 1'b1, 1'b0, c + 8'h02, 8'h00, 8'h00);
            run(1'b1, 1'b1, 1'b1, c + 8'h01, 8'h01, 8'h00);
        end
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        rd_chk(OFF_PIO_ASSERT_TIME, 8'h00);
        rd_chk(OFF_PIO_RECOVERY_TIME, 8'h00);
        rd_chk(OFF_DMA_ASSERT_TIME, 8'h00);
        results();
    end
endmodule : testbench
